// *** reset_seq_pkg.sv ***
package reset_seq_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int POR_DELAY_NS = 10_000;
    localparam int VREG_DELAY_NS = 10_000;
    localparam int POWER_UP_TIMER_DELAY_NS = 64_000_000;
    localparam int PLL_LOCK_NS = 2_000_000;
    localparam int MON_START_NS = 100_000;
    // least times, rounded up to whole cycles
    localparam int POR_CYC = (POR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int VREG_CYC = (VREG_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POWER_UP_TIMER_CYC = (POWER_UP_TIMER_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PLL_LOCK_CYC = (PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MON_START_CYC = (MON_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TRST_CYC = 16;
    localparam int OST_W = 10;
    localparam logic [OST_W-1:0] OST_LAST = 10'h3ff;
    localparam int CNT_W = 24;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam logic [ADDR_W-1:0] REG_CAUSE = 4'h0;
    localparam logic [ADDR_W-1:0] REG_OSC = 4'h1;
    localparam logic [ADDR_W-1:0] REG_RTC_CAL = 4'h2;
    localparam logic [ADDR_W-1:0] REG_NVM = 4'h3;
    localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 4'h4;
    localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 4'h5;
    localparam logic [ADDR_W-1:0] REG_SEQ_STAT = 4'h6;
    localparam int CAUSE_TRAP = 15;
    localparam int CAUSE_OPCODE = 14;
    localparam int CAUSE_PIN = 7;
    localparam int CAUSE_SW = 6;
    localparam int CAUSE_WDT = 4;
    localparam int CAUSE_BOR = 1;
    localparam int CAUSE_POR = 0;
    localparam logic [DATA_W-1:0] CAUSE_MASK = 16'hc0d3;
    localparam logic [DATA_W-1:0] CAUSE_POR_VAL = 16'h0003;
    localparam int OSC_CUR_LSB = 12;
    localparam int OSC_FAIL_BIT = 3;
    localparam int CFG_INIT_LSB = 8;
    localparam logic [2:0] OSC_FRC = 3'h0;
    localparam logic [2:0] OSC_FRCPLL = 3'h1;
    localparam logic [2:0] OSC_PRI = 3'h2;
    localparam logic [2:0] OSC_PRIPLL = 3'h3;
    localparam logic [2:0] OSC_SECONDARY_OSC = 3'h4;
    localparam int N_SRC = 8;
    localparam int SRC_POR = 0;
    localparam int SRC_BOR = 1;
    localparam int SRC_PIN = 2;
    localparam int SRC_WDT = 3;
    localparam int SRC_SW = 4;
    localparam int SRC_TRAP = 5;
    localparam int SRC_OPC = 6;
    localparam int SRC_UNW = 7;
    localparam int IRQ_W = 3;
    localparam int IRQ_RST_REL = 0;
    localparam int IRQ_CLK_REL = 1;
    localparam int IRQ_FAIL = 2;

    typedef logic [CNT_W-1:0] cnt_type;
    typedef enum logic [1:0] {kind_short = 2'h0, kind_bor = 2'h1, kind_por = 2'h2} kind_type;
    typedef enum logic [2:0] {
        st_src = 3'h0, st_por = 3'h1, st_startup = 3'h3, st_trst = 3'h2, st_run = 3'h6
    } seq_state_type;
    typedef enum logic [1:0] {ck_ready = 2'h0, ck_ost = 2'h1, ck_lock = 2'h3} clk_phase_type;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } bus_req_type;

    typedef struct packed {
        logic [N_SRC-1:0] src_s1;
        logic [N_SRC-1:0] src_s2;
        logic tick_s1;
        logic tick_s2;
        logic tick_s3;
        logic valid_s1;
        logic valid_s2;
        seq_state_type st;
        kind_type kind;
        cnt_type cnt;
        logic [2:0] sel;
        clk_phase_type phase;
        cnt_type clk_cnt;
        logic [OST_W-1:0] ost_cnt;
        logic clk_ready;
        logic mon_wait;
        logic mon_on;
        cnt_type mon_cnt;
        logic fail_pulse;
        logic fail_flag;
        logic [DATA_W-1:0] cause;
        logic [DATA_W-1:0] rtc_cal;
        logic [DATA_W-1:0] nvm;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic [DATA_W-1:0] rdata;
    } state_type;

    localparam state_type RESET_STATE = '{
        src_s1: '0, src_s2: '0, tick_s1: 1'b0, tick_s2: 1'b0, tick_s3: 1'b0,
        valid_s1: 1'b0, valid_s2: 1'b0, st: st_src, kind: kind_por, cnt: '0,
        sel: OSC_FRC, phase: ck_ready, clk_cnt: '0, ost_cnt: '0, clk_ready: 1'b0,
        mon_wait: 1'b0, mon_on: 1'b0, mon_cnt: '0, fail_pulse: 1'b0, fail_flag: 1'b0,
        cause: CAUSE_POR_VAL, rtc_cal: '0, nvm: '0, irq_stat: '0, irq_mask: '0, rdata: '0
    };
endpackage : reset_seq_pkg

// *** reset_release_sequencer.sv ***
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module reset_release_sequencer #(
    parameter int unsigned POWER_UP_TIMER_CYCLES = reset_seq_pkg::POWER_UP_TIMER_CYC,
    parameter int unsigned PLL_LOCK_CYCLES = reset_seq_pkg::PLL_LOCK_CYC,
    parameter int unsigned MON_START_CYCLES = reset_seq_pkg::MON_START_CYC
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [reset_seq_pkg::N_SRC-1:0] reset_src,
    input wire logic clock_switch_en,
    input wire logic regulator_en,
    input wire logic monitor_en,
    input wire logic primary_is_crystal,
    input wire logic [reset_seq_pkg::DATA_W-1:0] config_word_two,
    input wire logic osc_tick,
    input wire logic osc_valid,
    input wire reset_seq_pkg::bus_req_type bus_req,
    output logic [reset_seq_pkg::DATA_W-1:0] rd_data,
    output logic system_reset_out,
    output logic cpu_run,
    output logic clk_released,
    output logic [2:0] clk_sel,
    output logic monitor_active,
    output logic osc_fail_trap,
    output logic irq
);
    import reset_seq_pkg::*;

    state_type q_ff;
    state_type nxt_q;
    logic any_src;
    logic leave_src;
    logic tick_edge;
    logic clk_ok;

    function automatic kind_type src_kind(input logic [N_SRC-1:0] s);
        if (s[SRC_POR]) return kind_por;
        if (s[SRC_BOR]) return kind_bor;
        return kind_short;
    endfunction : src_kind

    function automatic logic needs_ost(input logic [2:0] s, input logic xtal);
        return (s == OSC_SECONDARY_OSC) || (xtal && (s == OSC_PRI || s == OSC_PRIPLL));
    endfunction : needs_ost

    function automatic logic needs_pll(input logic [2:0] s);
        return (s == OSC_FRCPLL) || (s == OSC_PRIPLL);
    endfunction : needs_pll

    function automatic logic hit(input bus_req_type r, input logic [ADDR_W-1:0] off);
        return r.addr == off;
    endfunction : hit

    function automatic logic [DATA_W-1:0] cause_bits(input logic [N_SRC-1:0] s);
        logic [DATA_W-1:0] c;
        c = '0;
        c[CAUSE_BOR] = s[SRC_BOR];
        c[CAUSE_PIN] = s[SRC_PIN];
        c[CAUSE_WDT] = s[SRC_WDT];
        c[CAUSE_SW] = s[SRC_SW];
        c[CAUSE_TRAP] = s[SRC_TRAP];
        c[CAUSE_OPCODE] = s[SRC_OPC] | s[SRC_UNW];
        return c;
    endfunction : cause_bits

    assign any_src = |q_ff.src_s2;
    assign leave_src = (q_ff.st == st_src) && !any_src;
    assign tick_edge = q_ff.tick_s2 & ~q_ff.tick_s3;
    assign clk_ok = q_ff.valid_s2 & q_ff.clk_ready;

    always_comb begin
        logic [2:0] new_sel;
        cnt_type lim;
        logic [IRQ_W-1:0] ev;
        new_sel = q_ff.sel;
        lim = '0;
        ev = '0;
        nxt_q = q_ff;
        // pins from other domains; stage one feeds stage two only
        nxt_q.src_s1 = reset_src;
        nxt_q.src_s2 = q_ff.src_s1;
        nxt_q.tick_s1 = osc_tick;
        nxt_q.tick_s2 = q_ff.tick_s1;
        nxt_q.tick_s3 = q_ff.tick_s2;
        nxt_q.valid_s1 = osc_valid;
        nxt_q.valid_s2 = q_ff.valid_s1;
        nxt_q.fail_pulse = 1'b0;

        // software writes first so hardware updates below win
        if (bus_req.wr) begin
            if (hit(bus_req, REG_CAUSE)) nxt_q.cause = bus_req.wdata & CAUSE_MASK;
            if (hit(bus_req, REG_OSC)) begin
                nxt_q.sel = bus_req.wdata[OSC_CUR_LSB +: 3];
                nxt_q.fail_flag = bus_req.wdata[OSC_FAIL_BIT];
            end
            if (hit(bus_req, REG_RTC_CAL)) nxt_q.rtc_cal = bus_req.wdata;
            if (hit(bus_req, REG_NVM)) nxt_q.nvm = bus_req.wdata;
            if (hit(bus_req, REG_IRQ_MASK)) nxt_q.irq_mask = bus_req.wdata[IRQ_W-1:0];
        end

        // clock release timers, independent of the reset delay
        case (q_ff.phase)
            ck_ost: begin
                if (tick_edge) begin
                    nxt_q.ost_cnt = q_ff.ost_cnt + 10'h001;
                    if (q_ff.ost_cnt == OST_LAST) begin
                        if (needs_pll(q_ff.sel)) begin
                            nxt_q.phase = ck_lock;
                            nxt_q.clk_cnt = '0;
                        end else begin
                            nxt_q.phase = ck_ready;
                            nxt_q.clk_ready = 1'b1;
                        end
                    end
                end
            end
            ck_lock: begin
                nxt_q.clk_cnt = q_ff.clk_cnt + 24'h000001;
                if (q_ff.clk_cnt == cnt_type'(PLL_LOCK_CYCLES - 1)) begin
                    nxt_q.phase = ck_ready;
                    nxt_q.clk_ready = 1'b1;
                end
            end
            ck_ready: ;
            default: nxt_q.phase = ck_ready;
        endcase

        // clock fail monitor
        if (q_ff.mon_wait) begin
            nxt_q.mon_cnt = q_ff.mon_cnt + 24'h000001;
            if (q_ff.mon_cnt == cnt_type'(MON_START_CYCLES - 1)) begin
                nxt_q.mon_wait = 1'b0;
                nxt_q.mon_on = 1'b1;
            end
        end
        if (q_ff.mon_on && !clk_ok) begin
            nxt_q.sel = OSC_FRC;
            nxt_q.phase = ck_ready;
            nxt_q.clk_ready = 1'b1;
            nxt_q.mon_on = 1'b0;
            nxt_q.fail_pulse = 1'b1;
            nxt_q.fail_flag = 1'b1;
            ev[IRQ_FAIL] = 1'b1;
        end

        // reset sequencer; an active source overrides the state, the delay count and the monitor
        if (any_src) begin
            nxt_q.st = st_src;
            nxt_q.cnt = '0;
            nxt_q.mon_wait = 1'b0;
            nxt_q.mon_on = 1'b0;
            if (q_ff.st != st_src || src_kind(q_ff.src_s2) > q_ff.kind) begin
                nxt_q.kind = src_kind(q_ff.src_s2);
            end
            nxt_q.cause = nxt_q.cause | cause_bits(q_ff.src_s2);
            if (q_ff.src_s2[SRC_POR]) begin
                nxt_q.cause = CAUSE_POR_VAL;
                nxt_q.rtc_cal = '0;
                nxt_q.nvm = '0;
            end
        end else begin
            case (q_ff.st)
                st_src: begin
                    // with clock_switch_en set, every reset other than power-on and brown-out keeps the running source
                    if (!clock_switch_en || q_ff.kind != kind_short) begin
                        new_sel = config_word_two[CFG_INIT_LSB +: 3];
                    end
                    nxt_q.sel = new_sel;
                    nxt_q.cnt = '0;
                    nxt_q.clk_cnt = '0;
                    nxt_q.ost_cnt = '0;
                    nxt_q.phase = ck_ready;
                    nxt_q.clk_ready = 1'b1;
                    if (q_ff.kind != kind_short) begin
                        if (needs_ost(new_sel, primary_is_crystal)) begin
                            nxt_q.phase = ck_ost;
                            nxt_q.clk_ready = 1'b0;
                        end else if (needs_pll(new_sel)) begin
                            nxt_q.phase = ck_lock;
                            nxt_q.clk_ready = 1'b0;
                        end
                    end
                    case (q_ff.kind)
                        kind_por: nxt_q.st = st_por;
                        kind_bor: nxt_q.st = st_startup;
                        default: nxt_q.st = st_trst;
                    endcase
                end
                st_por: begin
                    nxt_q.cnt = q_ff.cnt + 24'h000001;
                    if (q_ff.cnt == cnt_type'(POR_CYC - 1)) begin
                        nxt_q.st = st_startup;
                        nxt_q.cnt = '0;
                    end
                end
                st_startup: begin
                    lim = regulator_en ? cnt_type'(VREG_CYC - 1) : cnt_type'(POWER_UP_TIMER_CYCLES - 1);
                    nxt_q.cnt = q_ff.cnt + 24'h000001;
                    if (q_ff.cnt == lim) begin
                        nxt_q.st = st_trst;
                        nxt_q.cnt = '0;
                    end
                end
                st_trst: begin
                    nxt_q.cnt = q_ff.cnt + 24'h000001;
                    if (q_ff.cnt == cnt_type'(TRST_CYC - 1)) begin
                        nxt_q.st = st_run;
                        ev[IRQ_RST_REL] = 1'b1;
                        if (monitor_en) begin
                            // after a power-on or brown-out, slow sources get settling time before checks start
                            if (q_ff.kind != kind_short && (needs_ost(q_ff.sel, primary_is_crystal)
                                    || needs_pll(q_ff.sel))) begin
                                nxt_q.mon_wait = 1'b1;
                                nxt_q.mon_cnt = '0;
                            end else begin
                                nxt_q.mon_on = 1'b1;
                            end
                        end
                    end
                end
                st_run: ;
                default: nxt_q.st = st_src;
            endcase
        end

        ev[IRQ_CLK_REL] = nxt_q.clk_ready & ~q_ff.clk_ready;

        // read clears the status; a same-cycle event still lands
        if (bus_req.rd && hit(bus_req, REG_IRQ_STAT)) nxt_q.irq_stat = '0;
        nxt_q.irq_stat = nxt_q.irq_stat | ev;

        nxt_q.rdata = '0;
        if (bus_req.rd) begin
            case (bus_req.addr)
                REG_CAUSE: nxt_q.rdata = q_ff.cause;
                REG_OSC: begin
                    nxt_q.rdata[OSC_CUR_LSB +: 3] = q_ff.sel;
                    nxt_q.rdata[OSC_FAIL_BIT] = q_ff.fail_flag;
                end
                REG_RTC_CAL: nxt_q.rdata = q_ff.rtc_cal;
                REG_NVM: nxt_q.rdata = q_ff.nvm;
                REG_IRQ_STAT: nxt_q.rdata = {13'h0, q_ff.irq_stat};
                REG_IRQ_MASK: nxt_q.rdata = {13'h0, q_ff.irq_mask};
                REG_SEQ_STAT: nxt_q.rdata = {6'h00, q_ff.mon_on, q_ff.mon_wait, q_ff.clk_ready,
                    q_ff.phase, q_ff.kind, q_ff.st};
                default: nxt_q.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            q_ff <= RESET_STATE;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign rd_data = q_ff.rdata;
    // the synced source gates the output at once; the state follows one cycle later
    assign system_reset_out = (q_ff.st != st_run) || any_src;
    assign cpu_run = (q_ff.st == st_run) && !any_src && q_ff.clk_ready;
    assign clk_released = q_ff.clk_ready;
    assign clk_sel = q_ff.sel;
    assign monitor_active = q_ff.mon_on;
    assign osc_fail_trap = q_ff.fail_pulse;
    assign irq = |(q_ff.irq_stat & q_ff.irq_mask);

    localparam cnt_type POR_LAST = cnt_type'(POR_CYC - 1);
    localparam cnt_type VREG_LAST = cnt_type'(VREG_CYC - 1);
    localparam cnt_type POWER_UP_TIMER_LAST = cnt_type'(POWER_UP_TIMER_CYCLES - 1);
    localparam cnt_type PLL_LAST = cnt_type'(PLL_LOCK_CYCLES - 1);
    localparam cnt_type MON_LAST = cnt_type'(MON_START_CYCLES - 1);

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence enter_trst_s;
        (q_ff.st == st_trst) && ($past(q_ff.st) != st_trst);
    endsequence
    sequence quiet_trst_s;
        (!any_src)[*8] ##1 (!any_src)[*8];
    endsequence
    sequence lock_last_s;
        q_ff.phase == ck_lock && q_ff.clk_cnt == PLL_LAST && !leave_src;
    endsequence

    src_holds_reset_a: assert property (any_src |-> system_reset_out)
        else $error("reset out low with a source active");
    release_path_a: assert property ((q_ff.st == st_run && $past(q_ff.st) != st_run)
        |-> $past(q_ff.st) == st_trst)
        else $error("reset released outside internal reset end");
    trst_hold_a: assert property (enter_trst_s |-> system_reset_out[*8])
        else $error("internal reset time too short");
    trst_end_a: assert property (enter_trst_s ##0 quiet_trst_s |=> q_ff.st == st_run)
        else $error("internal reset time not ended on time");
    por_delay_a: assert property ((q_ff.st == st_por && q_ff.cnt == POR_LAST && !any_src)
        |=> q_ff.st == st_startup)
        else $error("power-on delay end wrong");
    vreg_delay_a: assert property ((q_ff.st == st_startup && regulator_en && !any_src
        && q_ff.cnt == VREG_LAST) |=> q_ff.st == st_trst)
        else $error("regulator delay end wrong");
    run_needs_clock_a: assert property (cpu_run |-> clk_released && !system_reset_out)
        else $error("execution without a released clock");
    por_cause_a: assert property ((q_ff.src_s2[SRC_POR]) |=> q_ff.cause == CAUSE_POR_VAL)
        else $error("power-on cause value wrong");
    keep_current_a: assert property ((leave_src && clock_switch_en && q_ff.kind == kind_short)
        |=> clk_sel == $past(clk_sel))
        else $error("short reset changed clock source");
    config_select_a: assert property ((leave_src && !clock_switch_en)
        |=> clk_sel == $past(config_word_two[CFG_INIT_LSB +: 3]))
        else $error("config source not taken");
    ost_start_a: assert property ((leave_src && q_ff.kind != kind_short
        && needs_ost(config_word_two[CFG_INIT_LSB +: 3], primary_is_crystal) && !clock_switch_en)
        |=> q_ff.phase == ck_ost && system_reset_out)
        else $error("start-up timer not started with reset delay");
    ost_count_a: assert property ((q_ff.phase == ck_ost && tick_edge && !leave_src && !any_src
        && !(q_ff.mon_on && !clk_ok)) |=> q_ff.ost_cnt == OST_W'($past(q_ff.ost_cnt) + 1))
        else $error("start-up timer missed an oscillator period");
    fail_switch_a: assert property ((q_ff.mon_on && !clk_ok && !any_src)
        |=> clk_sel == OSC_FRC && osc_fail_trap ##1 !osc_fail_trap)
        else $error("clock failure not handled");
    mon_gate_a: assert property (q_ff.mon_wait |-> !monitor_active)
        else $error("monitor checked during start delay");
    rtc_keep_a: assert property ((q_ff.src_s2[SRC_WDT] && !q_ff.src_s2[SRC_POR]
        && !(bus_req.wr && bus_req.addr == REG_RTC_CAL)) |=> $stable(q_ff.rtc_cal))
        else $error("calibration lost on non power-on reset");
    nvm_keep_a: assert property ((q_ff.src_s2[SRC_PIN] && !q_ff.src_s2[SRC_POR]
        && !(bus_req.wr && bus_req.addr == REG_NVM)) |=> $stable(q_ff.nvm))
        else $error("nvm control lost on non power-on reset");

    power_up_timer_delay_a: assert property ((q_ff.st == st_startup && !regulator_en && !any_src
        && q_ff.cnt == POWER_UP_TIMER_LAST) |=> q_ff.st == st_trst)
        else $error("power-up timer end wrong");
    // a monitor trap forces release early, so the early check leaves it out
    lock_early_a: assert property ((q_ff.phase == ck_lock && q_ff.clk_cnt != PLL_LAST
        && !leave_src && !(q_ff.mon_on && !clk_ok)) |=> !clk_released)
        else $error("clock released before lock time");
    lock_end_a: assert property (lock_last_s |=> clk_released)
        else $error("clock not released after lock time");
    ost_to_lock_a: assert property ((q_ff.phase == ck_ost && tick_edge
        && q_ff.ost_cnt == OST_LAST && needs_pll(q_ff.sel) && !leave_src
        && !(q_ff.mon_on && !clk_ok)) |=> q_ff.phase == ck_lock)
        else $error("lock wait not started after start-up count");
    short_clock_a: assert property ((leave_src && q_ff.kind == kind_short)
        |=> clk_released)
        else $error("short reset delayed the clock");
    mon_start_a: assert property ((q_ff.mon_wait && q_ff.mon_cnt == MON_LAST && !any_src)
        |=> monitor_active)
        else $error("monitor not started after start delay");
    fail_status_a: assert property ((q_ff.mon_on && !clk_ok && !any_src)
        |=> q_ff.irq_stat[IRQ_FAIL] && q_ff.fail_flag)
        else $error("clock failure not recorded");
    por_clear_a: assert property (q_ff.src_s2[SRC_POR]
        |=> q_ff.rtc_cal == '0 && q_ff.nvm == '0)
        else $error("power-on did not clear calibration");
    cause_wdt_a: assert property ((q_ff.src_s2[SRC_WDT] && !q_ff.src_s2[SRC_POR])
        |=> q_ff.cause[CAUSE_WDT])
        else $error("watchdog cause not recorded");
endmodule : reset_release_sequencer

// *** osc_model.sv ***
`timescale 1ns/1ps
module osc_model #(
    parameter int HALF = 2
) (
    input wire logic clk_sys,
    input wire logic run_en,
    output logic osc_tick,
    output logic osc_valid
);
    int cnt;
    // a stopped oscillator does not swing, so the tick stands low
    always_ff @(posedge clk_sys) begin
        if (!run_en) begin
            cnt <= 0;
            osc_tick <= 1'b0;
        end else if (cnt == HALF - 1) begin
            cnt <= 0;
            osc_tick <= ~osc_tick;
        end else begin
            cnt <= cnt + 1;
        end
    end
    assign osc_valid = run_en;
endmodule : osc_model

// *** testbench.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
    $display("Error %0t: got %h exp %h", $time, g, e); end end
module testbench;
    import reset_seq_pkg::*;
    localparam int POWER_UP_TIMER = 50;
    localparam int PLL = 20;
    localparam int MON = 10;
    localparam int HALF = 2;
    localparam int LONG = POR_CYC + VREG_CYC + TRST_CYC;
    localparam int W_RST = 0;
    localparam int W_CLK = 1;
    localparam int W_FAIL = 2;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [N_SRC-1:0] reset_src = '0;
    logic sw_en = 1'b1;
    logic reg_en = 1'b1;
    logic mon_en = 1'b0;
    logic [DATA_W-1:0] cfg = '0;
    logic osc_run = 1'b0;
    logic xtal = 1'b1;
    logic osc_tick, osc_valid, system_reset_out, cpu_run, clk_released;
    logic monitor_active, osc_fail_trap, irq;
    logic [2:0] clk_sel;
    logic [DATA_W-1:0] rd_data;
    bus_req_type bus_req = '0;
    int err_total = 0;
    int check_count = 0;

    initial forever #5 clk_sys = ~clk_sys;

    osc_model #(.HALF(HALF)) u_osc (.clk_sys(clk_sys), .run_en(osc_run),
        .osc_tick(osc_tick), .osc_valid(osc_valid));

    reset_release_sequencer #(.POWER_UP_TIMER_CYCLES(POWER_UP_TIMER), .PLL_LOCK_CYCLES(PLL),
        .MON_START_CYCLES(MON)) u_dut (
        .clk_sys(clk_sys), .rst(rst), .reset_src(reset_src), .clock_switch_en(sw_en),
        .regulator_en(reg_en), .monitor_en(mon_en), .primary_is_crystal(xtal),
        .config_word_two(cfg), .osc_tick(osc_tick), .osc_valid(osc_valid),
        .bus_req(bus_req), .rd_data(rd_data), .system_reset_out(system_reset_out),
        .cpu_run(cpu_run), .clk_released(clk_released), .clk_sel(clk_sel),
        .monitor_active(monitor_active), .osc_fail_trap(osc_fail_trap), .irq(irq));

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_sys);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_sys);
        bus_req <= '0;
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk_sys);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: '0};
        @(posedge clk_sys);
        bus_req <= '0;
        #1 d = rd_data;
    endtask : rd

    // bounded so a stuck sequence ends as a mismatch, not a hang
    function automatic logic probe(input int which);
        case (which)
            W_RST: return system_reset_out;
            W_CLK: return clk_released;
            default: return osc_fail_trap;
        endcase
    endfunction : probe

    task automatic wait_for(input int which, input logic lvl, output int n);
        n = 0;
        while (probe(which) !== lvl && n < 9000) begin
            @(posedge clk_sys);
            #1 n++;
        end
    endtask : wait_for

    task automatic pulse(input int idx, input int hold, input int lo, output int n);
        @(posedge clk_sys);
        reset_src[idx] <= 1'b1;
        repeat (hold) @(posedge clk_sys);
        reset_src[idx] <= 1'b0;
        #1;
        `CHK(system_reset_out, 1'b1)
        `CHK(cpu_run, 1'b0)
        wait_for(W_RST, 1'b0, n);
        `CHK(n >= lo && n <= lo + 6, 1'b1)
    endtask : pulse

    function automatic logic [DATA_W-1:0] cause_of(input int s);
        return 16'h0001 << (s == SRC_PIN ? CAUSE_PIN : s == SRC_WDT ? CAUSE_WDT :
            s == SRC_SW ? CAUSE_SW : s == SRC_TRAP ? CAUSE_TRAP : CAUSE_OPCODE);
    endfunction : cause_of

    initial begin
        #300_000;
        err_total++;
        $display("Error %0t: watchdog expired", $time);
        tally_and_finish();
    end

    initial begin
        logic [DATA_W-1:0] d, cal, nv;
        int n, m, s;
        void'($urandom(32'h6f930cb3));
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        osc_run <= 1'b1;
        wait_for(W_RST, 1'b0, n);
        `CHK(n >= LONG && n <= LONG + 6, 1'b1)
        rd(REG_CAUSE, d);
        `CHK(d, CAUSE_POR_VAL)
        `CHK(cpu_run, 1'b1)
        wr(REG_IRQ_MASK, 16'h0001);
        rd(REG_IRQ_STAT, d);
        `CHK(d[IRQ_RST_REL], 1'b1)
        #1;
        `CHK(irq, 1'b0)
        rd(4'hf, d);
        `CHK(d, 16'h0000)
        $display("test power-on done");
        cal = DATA_W'($urandom);
        nv = DATA_W'($urandom);
        wr(REG_RTC_CAL, cal);
        wr(REG_NVM, nv);
        for (int i = 0; i < 6; i++) begin
            s = $urandom_range(SRC_UNW, SRC_PIN);
            wr(REG_CAUSE, 16'h0000);
            pulse(s, $urandom_range(8, 4), TRST_CYC, n);
            rd(REG_CAUSE, d);
            `CHK(d, cause_of(s))
        end
        rd(REG_RTC_CAL, d);
        `CHK(d, cal)
        rd(REG_NVM, d);
        `CHK(d, nv)
        $display("test short resets done");
        reg_en <= 1'b0;
        xtal <= 1'b0;
        cfg <= {5'h00, OSC_PRI, 8'h00};
        wr(REG_CAUSE, 16'h0000);
        pulse(SRC_BOR, 4, POWER_UP_TIMER + TRST_CYC, n);
        // a clock input that is no crystal is released with no start-up count
        `CHK(clk_released, 1'b1)
        `CHK(clk_sel, OSC_PRI)
        rd(REG_CAUSE, d);
        `CHK(d, 16'h0001 << CAUSE_BOR)
        reg_en <= 1'b1;
        xtal <= 1'b1;
        $display("test brown-out done");
        cfg <= {5'h00, OSC_PRIPLL, 8'h00};
        pulse(SRC_POR, 4, LONG, n);
        `CHK(cpu_run, 1'b0)
        wait_for(W_CLK, 1'b1, m);
        // crystal count then lock, overlapping the reset delay
        `CHK(n + m >= 2048 * HALF + PLL && n + m <= 2048 * HALF + PLL + 16, 1'b1)
        `CHK(n + m < LONG + 2048 * HALF, 1'b1)
        `CHK(cpu_run, 1'b1)
        `CHK(clk_sel, OSC_PRIPLL)
        rd(REG_RTC_CAL, d);
        `CHK(d, 16'h0000)
        rd(REG_CAUSE, d);
        `CHK(d, CAUSE_POR_VAL)
        $display("test crystal pll done");
        wr(REG_OSC, {1'b0, OSC_PRI, 12'h000});
        pulse(SRC_WDT, 4, TRST_CYC, n);
        `CHK(clk_sel, OSC_PRI)
        sw_en <= 1'b0;
        pulse(SRC_SW, 4, TRST_CYC, n);
        `CHK(clk_sel, OSC_PRIPLL)
        sw_en <= 1'b1;
        $display("test clock select done");
        mon_en <= 1'b1;
        cfg <= {5'h00, OSC_PRI, 8'h00};
        wr(REG_IRQ_MASK, 16'h0004);
        pulse(SRC_POR, 4, LONG, n);
        `CHK(monitor_active, 1'b0)
        wait_for(W_FAIL, 1'b1, n);
        `CHK(n >= MON && n <= MON + 4, 1'b1)
        `CHK(clk_sel, OSC_FRC)
        `CHK(clk_released, 1'b1)
        #10;
        `CHK(irq, 1'b1)
        rd(REG_OSC, d);
        `CHK(d[OSC_FAIL_BIT], 1'b1)
        $display("test clock fail done");
        tally_and_finish();
    end
endmodule : testbench
